// file: hdl/bpd_defs.svh
`ifndef BPD_DEFS_SVH
`define BPD_DEFS_SVH
`define BPD_PREFIX_OPCODE    8'h11
`define BPD_ADDR_WIDTH       20
`define BPD_BANK_MSB         19
`define BPD_BANK_LSB         16
`define BPD_HIGH_MSB         15
`define BPD_HIGH_LSB         8
`define BPD_LOW_MSB          7
`define BPD_LOW_LSB          0
`define BPD_DEFAULT_BANK     4'hF
`define BPD_TABLE_LO         16'h0080
`define BPD_TABLE_HI         16'h00BF
`define BPD_REG_FETCH        12'h000
`define BPD_REG_EXEC         12'h004
`define BPD_REG_BANK         12'h008
`define BPD_REG_FLAGCTL      12'h00C
`define BPD_REG_FLAGS        12'h010
`define BPD_REG_STATUS       12'h014
`define BPD_REG_ACC          12'h018
`define BPD_REG_PAIR_BC      12'h01C
`define BPD_REG_PAIR_DE      12'h020
`define BPD_REG_PAIR_HL      12'h024
`define BPD_REG_ADDR_IN      12'h028
`define BPD_REG_ADDR_OUT     12'h02C
`define BPD_REG_OPERAND      12'h030
`define BPD_REG_BRANCH       12'h034
`define BPD_REG_PC           12'h038
`define BPD_REG_REQ          12'h03C
`define BPD_FLAG_Z           2
`define BPD_FLAG_HALF_CARRY  1
`define BPD_FLAG_CARRY       0
`endif

// file: hdl/bpd_pkg.sv
package bpd_pkg;
    typedef enum logic [2:0] {
        BPD_FLAG_KEEP,
        BPD_FLAG_CLEAR,
        BPD_FLAG_SET,
        BPD_FLAG_RESULT,
        BPD_FLAG_RESTORE
    } bpd_flag_mode_e;
    typedef enum {
        BPD_IDLE,
        BPD_PREFIXED
    } bpd_state_e;
endpackage

// file: hdl/bpd_flag_unit.sv
`timescale 1ns/1ps
module bpd_flag_unit (
    input  wire logic                    cur_i,
    input  wire logic                    result_i,
    input  wire logic                    saved_i,
    input  wire bpd_pkg::bpd_flag_mode_e mode_i,
    output logic                         next_o
);
    import bpd_pkg::*;
    // One flag's update by its five behaviours
    always_comb begin
        case (mode_i)
            BPD_FLAG_KEEP:    next_o = cur_i;
            BPD_FLAG_CLEAR:   next_o = 1'b0;
            BPD_FLAG_SET:     next_o = 1'b1;
            BPD_FLAG_RESULT:  next_o = result_i;
            BPD_FLAG_RESTORE: next_o = saved_i;
            default:          next_o = cur_i;
        endcase
    end
endmodule

// file: hdl/bpd_operand_unit.sv
`timescale 1ns/1ps
`include "bpd_defs.svh"
module bpd_operand_unit (
    input  wire logic [15:0] operand_i,
    input  wire logic        long_i,
    input  wire logic [19:0] pc_i,
    output logic [19:0]      target_o,
    output logic             table_ok_o
);
    logic [19:0] disp_ext;
    // Sign extension of short or long offset before adding to the counter
    always_comb begin
        if (long_i) begin
            disp_ext = {{4{operand_i[15]}}, operand_i};
        end else begin
            disp_ext = {{12{operand_i[7]}}, operand_i[7:0]};
        end
        target_o   = pc_i + disp_ext;
        table_ok_o = (operand_i >= `BPD_TABLE_LO) && (operand_i <= `BPD_TABLE_HI)
                     && !operand_i[0];
    end
endmodule

// file: hdl/bpd_decoder.sv
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "bpd_defs.svh"
// How it works
// - Prefixed access address is bank register above the 16-bit address.
// - Fetched byte 11H marks prefix; the next opcode is decoded unchanged.
// - Override lasts for exactly one following instruction, then clears.
// - Interrupt and DMA grants are blocked from prefix until instruction completes.
// - Zero, half-carry, carry each keep, clear, set, compute or restore.
// - 20-bit value splits into bank 19:16, high 15:8, low 7:0.
// - Table-call operand valid only when even within 0080H to 00BFH.
// - Short and long offsets sign-extend before adding to program counter.
// - Byte accumulator, companion byte, and three 16-bit pairs are held.
module bpd_decoder (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        irq_req_i,
    input  wire logic        dma_req_i,
    output logic             irq_ack_o,
    output logic             dma_grant_o
);
    import bpd_pkg::*;

    typedef struct packed {
        logic        prefixed;
        logic [3:0]  bank;
        logic [2:0]  flags;
        logic [2:0]  saved;
        logic [8:0]  flagctl_dummy;
        logic [7:0]  acc_lo;
        logic [7:0]  acc_hi;
        logic [15:0] pair_bc;
        logic [15:0] pair_de;
        logic [15:0] pair_hl;
        logic [15:0] addr_in;
        logic [19:0] addr_out;
        logic        ext_out;
        logic [15:0] operand;
        logic        long_sel;
        logic [19:0] pc;
        logic [19:0] target;
        logic        table_ok;
        logic [7:0]  last_op;
        logic        irq_ack;
        logic        dma_grant;
        logic [31:0] rdata;
    } bpd_state_s;

    bpd_state_s q, d;
    logic        wr_en;
    logic        rd_en;
    logic [2:0]  flag_next;
    logic [2:0]  result_flags;
    logic [8:0]  modes;
    logic [19:0] target_w;
    logic        table_ok_w;
    logic        blocked;
    logic        exec_w;

    assign wr_en   = psel && penable && pwrite;
    // Reads load data in the setup cycle, so it stands through the access phase
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = q.rdata;
    assign irq_ack_o   = q.irq_ack;
    assign dma_grant_o = q.dma_grant;
    assign modes       = q.flagctl_dummy;
    assign result_flags = pwdata[6:4];
    assign blocked     = q.prefixed;
    assign exec_w      = wr_en && (paddr == `BPD_REG_EXEC);

    // Per-flag update units
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_flag
            bpd_flag_unit u_flag (
                .cur_i    (q.flags[g]),
                .result_i (result_flags[g]),
                .saved_i  (q.saved[g]),
                .mode_i   (bpd_flag_mode_e'(modes[g*3 +: 3])),
                .next_o   (flag_next[g])
            );
        end
    endgenerate

    // Operand interpretation
    bpd_operand_unit u_oper (
        .operand_i  (q.operand),
        .long_i     (q.long_sel),
        .pc_i       (q.pc),
        .target_o   (target_w),
        .table_ok_o (table_ok_w)
    );

    // Next-state logic for decode, registers and bus
    always_comb begin
        d = q;
        d.irq_ack   = 1'b0;
        d.dma_grant = 1'b0;
        d.target    = target_w;
        d.table_ok  = table_ok_w;
        // Acknowledge only outside a prefix pair
        if (!blocked && irq_req_i) begin
            d.irq_ack = 1'b1;
        end
        if (!blocked && dma_req_i && !irq_req_i) begin
            d.dma_grant = 1'b1;
        end
        if (wr_en) begin
            case (paddr)
                `BPD_REG_FETCH: begin
                    d.last_op = pwdata[7:0];
                    if (pwdata[7:0] == `BPD_PREFIX_OPCODE && !q.prefixed) begin
                        d.prefixed = 1'b1;
                    end
                end
                `BPD_REG_EXEC: begin
                    // Instruction completes; prefix consumed
                    if (q.prefixed) begin
                        d.addr_out = {q.bank, q.addr_in};
                        d.ext_out  = 1'b1;
                    end else begin
                        d.addr_out = {`BPD_DEFAULT_BANK, q.addr_in};
                        d.ext_out  = 1'b0;
                    end
                    d.prefixed = 1'b0;
                    d.saved    = q.flags;
                    d.flags    = flag_next;
                end
                `BPD_REG_BANK:    d.bank = pwdata[3:0];
                `BPD_REG_FLAGCTL: d.flagctl_dummy = pwdata[8:0];
                `BPD_REG_FLAGS:   d.flags = pwdata[2:0];
                `BPD_REG_ACC: begin
                    d.acc_lo = pwdata[7:0];
                    d.acc_hi = pwdata[15:8];
                end
                `BPD_REG_PAIR_BC: d.pair_bc = pwdata[15:0];
                `BPD_REG_PAIR_DE: d.pair_de = pwdata[15:0];
                `BPD_REG_PAIR_HL: d.pair_hl = pwdata[15:0];
                `BPD_REG_ADDR_IN: d.addr_in = pwdata[15:0];
                `BPD_REG_OPERAND: begin
                    d.operand  = pwdata[15:0];
                    d.long_sel = pwdata[16];
                end
                `BPD_REG_PC:      d.pc = pwdata[19:0];
                default: begin
                end
            endcase
        end
        // Read data holds until the setup cycle of the next read
        if (rd_en) begin
            case (paddr)
                `BPD_REG_FETCH:   d.rdata = {24'h000000, q.last_op};
                `BPD_REG_BANK:    d.rdata = {28'h0000000, q.bank};
                `BPD_REG_FLAGCTL: d.rdata = {23'h000000, q.flagctl_dummy};
                `BPD_REG_FLAGS:   d.rdata = {29'h00000000, q.flags};
                `BPD_REG_STATUS:  d.rdata = {29'h00000000, q.ext_out, q.table_ok,
                                             q.prefixed};
                `BPD_REG_ACC:     d.rdata = {16'h0000, q.acc_hi, q.acc_lo};
                `BPD_REG_PAIR_BC: d.rdata = {16'h0000, q.pair_bc};
                `BPD_REG_PAIR_DE: d.rdata = {16'h0000, q.pair_de};
                `BPD_REG_PAIR_HL: d.rdata = {16'h0000, q.pair_hl};
                `BPD_REG_ADDR_IN: d.rdata = {16'h0000, q.addr_in};
                // Fields placed bank, high, low
                `BPD_REG_ADDR_OUT: d.rdata = {12'h000,
                    q.addr_out[`BPD_BANK_MSB:`BPD_BANK_LSB],
                    q.addr_out[`BPD_HIGH_MSB:`BPD_HIGH_LSB],
                    q.addr_out[`BPD_LOW_MSB:`BPD_LOW_LSB]};
                `BPD_REG_OPERAND: d.rdata = {15'h0000, q.long_sel, q.operand};
                `BPD_REG_BRANCH:  d.rdata = {12'h000, q.target};
                `BPD_REG_PC:      d.rdata = {12'h000, q.pc};
                default:          d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Grants are held off across a prefixed pair and resume right after it
    a_no_ack_prefix: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        q.prefixed |=> !irq_ack_o && !dma_grant_o)
        else $error("grant during prefix");
    a_irq_resume: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!q.prefixed && irq_req_i) |=> irq_ack_o)
        else $error("interrupt not acknowledged");
    a_dma_resume: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!q.prefixed && dma_req_i && !irq_req_i) |=> dma_grant_o)
        else $error("transfer not granted");

    // Prefix detection and its one-instruction lifetime
    a_prefix_sets: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_en && paddr == `BPD_REG_FETCH && pwdata[7:0] == 8'h11) |=> q.prefixed)
        else $error("prefix not seen");
    a_one_shot: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        exec_w |=> !q.prefixed)
        else $error("prefix kept");
    a_plain_ext: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (exec_w && !q.prefixed) |=> !q.ext_out)
        else $error("extension without prefix");

    // Address forming, bank sampling and field layout
    a_ext_addr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (exec_w && q.prefixed) |=> q.addr_out == {$past(q.bank), $past(q.addr_in)})
        else $error("bad ext addr");
    a_plain_addr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (exec_w && !q.prefixed) |=> q.addr_out[19:16] == `BPD_DEFAULT_BANK)
        else $error("bad window");
    a_bank_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_en && paddr == `BPD_REG_BANK) |=> q.bank == $past(pwdata[3:0]))
        else $error("bank not loaded");
    a_bank_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !(wr_en && paddr == `BPD_REG_BANK) |=> $stable(q.bank))
        else $error("bank moved");
    a_addr_in_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_en && paddr == `BPD_REG_ADDR_IN) |=> q.addr_in == $past(pwdata[15:0]))
        else $error("address not loaded");
    a_field_split: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (rd_en && paddr == `BPD_REG_ADDR_OUT) |=> prdata == {12'h000, $past(q.addr_out)})
        else $error("field layout");

    // Flag behaviours at instruction completion
    a_flag_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (exec_w && q.flagctl_dummy == 9'h000) |=> $stable(q.flags))
        else $error("flags moved");
    a_flag_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (exec_w && q.flagctl_dummy == 9'h092) |=> q.flags == 3'b111)
        else $error("flags not set");
    a_flag_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (exec_w && q.flagctl_dummy == 9'h049) |=> q.flags == 3'b000)
        else $error("flags not cleared");
    a_flag_restore: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (exec_w && q.flagctl_dummy == 9'h124) |=> q.flags == $past(q.saved))
        else $error("flags not restored");
    a_flag_saved: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        exec_w |=> q.saved == $past(q.flags))
        else $error("flags not saved");

    // Operand interpretation
    a_table_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        table_ok_w |-> (q.operand >= 16'h0080 && q.operand <= 16'h00BF && !q.operand[0]))
        else $error("table range");
    a_table_odd: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        q.operand[0] |-> !table_ok_w)
        else $error("odd table address");
    a_table_inside: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (q.operand >= 16'h0080 && q.operand <= 16'h00BF && !q.operand[0]) |-> table_ok_w)
        else $error("table address refused");
    a_short_branch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !q.long_sel |-> target_w == q.pc + {{12{q.operand[7]}}, q.operand[7:0]})
        else $error("branch ext");
    a_long_branch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        q.long_sel |-> target_w == q.pc + {{4{q.operand[15]}}, q.operand})
        else $error("long branch ext");
    a_pc_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_en && paddr == `BPD_REG_PC) |=> q.pc == $past(pwdata[19:0]))
        else $error("counter not loaded");

    // Register file
    a_acc_word: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_en && paddr == `BPD_REG_ACC) |=> {q.acc_hi, q.acc_lo} == $past(pwdata[15:0]))
        else $error("accumulator not loaded");
    a_pair_bc: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_en && paddr == `BPD_REG_PAIR_BC) |=> q.pair_bc == $past(pwdata[15:0]))
        else $error("first pair not loaded");
    a_pair_de: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_en && paddr == `BPD_REG_PAIR_DE) |=> q.pair_de == $past(pwdata[15:0]))
        else $error("second pair not loaded");
    a_pair_hl: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (wr_en && paddr == `BPD_REG_PAIR_HL) |=> q.pair_hl == $past(pwdata[15:0]))
        else $error("third pair not loaded");

    // Read data stands between reads
    a_rdata_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !rd_en |=> $stable(prdata))
        else $error("read data moved");

    // Main scenarios reached
    c_prefix_exec: cover property (@(posedge clk_i) q.prefixed ##[1:8] !q.prefixed);
    c_irq_held: cover property (@(posedge clk_i) q.prefixed && irq_req_i);
    c_dma_grant: cover property (@(posedge clk_i) dma_grant_o);
    c_long_branch: cover property (@(posedge clk_i) q.long_sel);
    c_flag_restore: cover property (@(posedge clk_i) exec_w && q.flagctl_dummy == 9'h124);
endmodule

// file: verif/bpd_req_model.sv
`timescale 1ns/1ps
// Interrupt and DMA requester on the far side of the decoder
module bpd_req_model (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        irq_en_i,
    input  wire logic        dma_en_i,
    input  wire logic        irq_ack_i,
    input  wire logic        dma_grant_i,
    output logic             irq_req_o,
    output logic             dma_req_o,
    output logic [15:0]      irq_cnt_o,
    output logic [15:0]      dma_cnt_o
);
    // Requests are levels held for as long as they are enabled
    assign irq_req_o = irq_en_i;
    assign dma_req_o = dma_en_i;
    // Count acknowledged cycles so the bench can see when grants came
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_cnt_o <= 16'h0000;
            dma_cnt_o <= 16'h0000;
        end else begin
            irq_cnt_o <= irq_cnt_o + {15'h0000, irq_ack_i === 1'b1};
            dma_cnt_o <= dma_cnt_o + {15'h0000, dma_grant_i === 1'b1};
        end
    end
endmodule

// file: verif/bank_prefix_operand_decoder_test.sv
`timescale 1ns/1ps
`include "bpd_defs.svh"
module bank_prefix_operand_decoder_test;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, irq_req, dma_req, irq_ack, dma_grant;
    logic        irq_en = 1'b0;
    logic        dma_en = 1'b0;
    logic [15:0] irq_cnt, dma_cnt;
    logic [31:0] rd;
    int          fail_count = 0;
    int          checked = 0;
    bpd_decoder bpd_decoder_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req_i(irq_req),
        .dma_req_i(dma_req), .irq_ack_o(irq_ack), .dma_grant_o(dma_grant));
    bpd_req_model bpd_req_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .irq_en_i(irq_en),
        .dma_en_i(dma_en), .irq_ack_i(irq_ack), .dma_grant_i(dma_grant),
        .irq_req_o(irq_req), .dma_req_o(dma_req), .irq_cnt_o(irq_cnt), .dma_cnt_o(dma_cnt));
    // Clock at 250 MHz
    always #2 clk_i = ~clk_i;
    // Verdict and end of run
    task end_of_test();
        $display("checks=%0d mismatches=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Compare one value and count it
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One APB transfer: setup, access until pready, read data taken there, one idle edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_count++;
                $display("CHECK FAILED t=%0t no ready", $time);
                end_of_test();
            end
            @(posedge clk_i);
        end
        rd = prdata;
        chk({31'h0, pslverr}, 32'h0000_0000, "error response");
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & mask, exp, "read value");
    endtask
    // Bank override widens exactly one instruction, sampled at execution
    task t_prefix();
        apb(1'b1, `BPD_REG_BANK, 32'h0000_0003);
        apb(1'b1, `BPD_REG_ADDR_IN, 32'h0000_1234);
        apb(1'b1, `BPD_REG_EXEC, 32'h0000_0000);
        rdchk(`BPD_REG_ADDR_OUT, 32'hFFFF_FFFF, 32'h000F_1234);
        apb(1'b1, `BPD_REG_FETCH, 32'h0000_008B);
        rdchk(`BPD_REG_STATUS, 32'h0000_0001, 32'h0000_0000);
        apb(1'b1, `BPD_REG_FETCH, {24'h000000, `BPD_PREFIX_OPCODE});
        apb(1'b1, `BPD_REG_FETCH, 32'h0000_008B);
        rdchk(`BPD_REG_STATUS, 32'h0000_0001, 32'h0000_0001);
        rdchk(`BPD_REG_FETCH, 32'h0000_00FF, 32'h0000_008B);
        apb(1'b1, `BPD_REG_EXEC, 32'h0000_0000);
        rdchk(`BPD_REG_ADDR_OUT, 32'hFFFF_FFFF, 32'h0003_1234);
        apb(1'b1, `BPD_REG_EXEC, 32'h0000_0000);
        rdchk(`BPD_REG_ADDR_OUT, 32'hFFFF_FFFF, 32'h000F_1234);
        apb(1'b1, `BPD_REG_FETCH, {24'h000000, `BPD_PREFIX_OPCODE});
        apb(1'b1, `BPD_REG_BANK, 32'h0000_000A);
        apb(1'b1, `BPD_REG_EXEC, 32'h0000_0000);
        rdchk(`BPD_REG_ADDR_OUT, 32'hFFFF_FFFF, 32'h000A_1234);
    endtask
    // Requests are held off across the prefixed pair, then granted
    task t_hold(input logic use_dma);
        logic [15:0] i0, d0;
        apb(1'b1, `BPD_REG_FETCH, {24'h000000, `BPD_PREFIX_OPCODE});
        i0 = irq_cnt; d0 = dma_cnt;
        irq_en <= ~use_dma; dma_en <= use_dma;
        repeat (6) @(posedge clk_i);
        chk({irq_cnt - i0, dma_cnt - d0}, 32'h0000_0000, "grant in prefix");
        apb(1'b1, `BPD_REG_EXEC, 32'h0000_0000);
        repeat (3) @(posedge clk_i);
        chk({31'h0, (use_dma ? dma_cnt != d0 : irq_cnt != i0)}, 32'h1, "no grant");
        irq_en <= 1'b0; dma_en <= 1'b0;
    endtask
    // Each flag mode applied per field
    task t_flags();
        apb(1'b1, `BPD_REG_FLAGCTL, 32'h0000_0092);
        apb(1'b1, `BPD_REG_EXEC, 32'h0000_0000);
        rdchk(`BPD_REG_FLAGS, 32'h0000_0007, 32'h0000_0007);
        apb(1'b1, `BPD_REG_FLAGCTL, 32'h0000_0043);
        apb(1'b1, `BPD_REG_EXEC, 32'h0000_0000);
        rdchk(`BPD_REG_FLAGS, 32'h0000_0007, 32'h0000_0002);
        apb(1'b1, `BPD_REG_FLAGCTL, 32'h0000_00C8);
        apb(1'b1, `BPD_REG_EXEC, 32'h0000_0070);
        rdchk(`BPD_REG_FLAGS, 32'h0000_0007, 32'h0000_0004);
        apb(1'b1, `BPD_REG_FLAGCTL, 32'h0000_0124);
        apb(1'b1, `BPD_REG_EXEC, 32'h0000_0000);
        rdchk(`BPD_REG_FLAGS, 32'h0000_0007, 32'h0000_0002);
        apb(1'b1, `BPD_REG_FLAGCTL, 32'h0000_0049);
        apb(1'b1, `BPD_REG_EXEC, 32'h0000_0070);
        rdchk(`BPD_REG_FLAGS, 32'h0000_0007, 32'h0000_0000);
    endtask
    // Branch offsets and table-call range
    task t_operand();
        logic [15:0] tv [5];
        logic        ok [5];
        tv = '{16'h0080, 16'h00BE, 16'h00BF, 16'h00C0, 16'h007E};
        ok = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        apb(1'b1, `BPD_REG_PC, 32'h0000_1000);
        apb(1'b1, `BPD_REG_OPERAND, 32'h0000_00F0);
        rdchk(`BPD_REG_BRANCH, 32'h000F_FFFF, 32'h0000_0FF0);
        apb(1'b1, `BPD_REG_OPERAND, 32'h0001_8000);
        rdchk(`BPD_REG_BRANCH, 32'h000F_FFFF, 32'h000F_9000);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `BPD_REG_OPERAND, {16'h0000, tv[i]});
            rdchk(`BPD_REG_STATUS, 32'h0000_0002, {30'h0, ok[i], 1'b0});
        end
    endtask
    // Accumulator, pairs and an unmapped place
    task t_regs();
        apb(1'b1, `BPD_REG_ACC, 32'h0000_A55A);
        rdchk(`BPD_REG_ACC, 32'h0000_FFFF, 32'h0000_A55A);
        apb(1'b1, `BPD_REG_PAIR_BC, 32'h0000_C3A1);
        apb(1'b1, `BPD_REG_PAIR_DE, 32'h0000_7E18);
        apb(1'b1, `BPD_REG_PAIR_HL, 32'h0000_BEEF);
        rdchk(`BPD_REG_PAIR_BC, 32'h0000_FFFF, 32'h0000_C3A1);
        rdchk(`BPD_REG_PAIR_DE, 32'h0000_FFFF, 32'h0000_7E18);
        rdchk(`BPD_REG_PAIR_HL, 32'h0000_FFFF, 32'h0000_BEEF);
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        rdchk(12'h0FC, 32'hFFFF_FFFF, 32'h0000_0000);
    endtask
    // Main sequence with a global cycle limit
    initial begin
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rdchk(`BPD_REG_FLAGS, 32'hFFFF_FFFF, 32'h0000_0000);
        t_prefix();
        t_hold(1'b0);
        t_hold(1'b1);
        t_flags();
        t_operand();
        t_regs();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        $display("CHECK FAILED t=%0t run limit", $time);
        end_of_test();
    end
endmodule
